// >>> prog_counter_array.sv
// Purpose: programmable counter array with one shared counter and five compare/capture units
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: pins not used by the array carry the general-purpose port values
// Notes on behaviour
// - counter clocked by div6, div2, timer0, pin
// - fast internal divider taken as divide-by-2
// - one counter shared by all five units
// - each unit runs exactly one function
// - all events merge onto one interrupt
// - unused pins stay general-purpose port lines
// - capture samples the synchronised module pin
// - edge copies counter into capture bytes
// - interrupt needs event flag and enable
// - timer compares counter with capture bytes
// - toggle output inverts on every match
// - pwm frequency set by shared counter
// - duty set by each capture low byte
// - pwm low below duty, high otherwise
// - low wrap reloads duty from high byte
// - pwm needs pwm and comparator enables
// - source codes 00 div6, 01 div2, 10 timer0, 11 pin
// - overflow flag set by hardware, software clears
// - idle stop bit halts counter in idle
`timescale 1ns/10ps
`include "counter_array_params.svh"

module prog_counter_array #(
   parameter int N_UNITS = 5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire counter_array_pkg::byte_t addr,
   input wire counter_array_pkg::byte_t wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output counter_array_pkg::byte_t rdata,
   // system events
   input wire logic timer0_ovf,
   input wire logic cpu_idle,
   // port pins
   input wire logic ext_count_pin,
   input wire logic [N_UNITS-1:0] io_pin_i,
   output logic [N_UNITS-1:0] io_pin_o,
   output logic [N_UNITS-1:0] io_pin_oe_n,
   // general-purpose port values for pins the array leaves free
   input wire logic [N_UNITS-1:0] gpio_o,
   input wire logic [N_UNITS-1:0] gpio_oe_n,
   // shared interrupt
   output logic irq
);
   import counter_array_pkg::*;

   byte_t cmode_q;
   logic ovf_q, run_q;
   logic [N_UNITS-1:0] flag_q, flag_d;
   count_t cnt_q;
   logic adv_q;
   logic [2:0] div_q;
   logic fast_q;
   logic ext_s1_q, ext_s2_q, ext_prev_q;
   logic slow_tick, src_tick, tick, run_ok, ovf_evt;
   logic wr_ctrl, wr_lo_cnt, wr_hi_cnt;
   clk_src_t src;
   byte_t mode_q [N_UNITS];
   logic [N_UNITS-1:0] ev, ie, drv, lvl;
   byte_t rdata_q, rd_mux;

   cc_link_if lnk [N_UNITS] ();

   ////////////////////////////////////////////////////////////////////////
   // register decode
   assign wr_ctrl = wr_en && addr == `ADDR_COUNTER_CTRL;
   assign wr_lo_cnt = wr_en && addr == `ADDR_COUNT_LO;
   assign wr_hi_cnt = wr_en && addr == `ADDR_COUNT_HI;

   // counter mode register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cmode_q <= `RST_BYTE;
      else if (wr_en && addr == `ADDR_COUNTER_MODE) cmode_q <= wdata & `CMODE_MASK;
   end

   assign src = clk_src_t'(cmode_q[`CMODE_SRC_HI:`CMODE_SRC_LO]);

   ////////////////////////////////////////////////////////////////////////
   // source dividers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 3'h0;
         fast_q <= 1'b0;
      end else begin
         div_q <= (div_q == 3'(`DIV_SLOW - 1)) ? 3'h0 : div_q + 3'h1;
         fast_q <= ~fast_q;
      end
   end

   assign slow_tick = (div_q == 3'(`DIV_SLOW - 1));

   // external count pin: two flops, then falling-edge detect
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_count_pin;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
      end
   end

   // source selection
   always_comb begin
      unique case (src)
         SRC_DIV_SLOW: src_tick = slow_tick;
         SRC_DIV_FAST: src_tick = fast_q;
         SRC_TIMER0: src_tick = timer0_ovf;
         SRC_EXT_PIN: src_tick = ext_prev_q & ~ext_s2_q;
      endcase
   end

   // run gate with idle stop
   assign run_ok = run_q && !(cmode_q[`CMODE_IDLE_STOP] && cpu_idle);
   assign tick = run_ok && src_tick;
   assign ovf_evt = tick && cnt_q == 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////
   // shared counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= `RST_COUNT;
      end else if (wr_lo_cnt) begin
         cnt_q <= {cnt_q[15:8], wdata};
      end else if (wr_hi_cnt) begin
         cnt_q <= {wdata, cnt_q[7:0]};
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // advance marker for unit compares
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) adv_q <= 1'b0;
      else adv_q <= tick && !wr_lo_cnt && !wr_hi_cnt;
   end

   ////////////////////////////////////////////////////////////////////////
   // counter control register: overflow, run, event flags
   always_comb begin
      flag_d = flag_q;
      if (wr_ctrl) flag_d = wdata[N_UNITS-1:0];
      flag_d = flag_d | ev; // set wins over clear
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_q <= 1'b0;
         run_q <= 1'b0;
         flag_q <= '0;
      end else begin
         if (wr_ctrl) run_q <= wdata[`CCTRL_RUN];
         ovf_q <= (wr_ctrl ? wdata[`CCTRL_OVF] : ovf_q) | ovf_evt;
         flag_q <= flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-unit mode registers and links
   for (genvar i = 0; i < N_UNITS; i++) begin : g_unit
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) mode_q[i] <= `RST_BYTE;
         else if (wr_en && addr == `ADDR_MODE_BASE + 8'(i)) mode_q[i] <= wdata & `MODE_MASK;
      end

      assign lnk[i].cnt = cnt_q;
      assign lnk[i].adv = adv_q;
      assign lnk[i].wr_lo = wr_en && addr == `ADDR_CAP_BASE + 8'(2 * i);
      assign lnk[i].wr_hi = wr_en && addr == `ADDR_CAP_BASE + 8'(2 * i + 1);
      assign lnk[i].wdata = wdata;
      assign lnk[i].mode = mode_q[i];
      assign lnk[i].pin_raw = io_pin_i[i];
      assign ev[i] = lnk[i].event_p;
      assign ie[i] = mode_q[i][`MODE_IE];
      assign drv[i] = lnk[i].drive;
      assign lvl[i] = lnk[i].pin_level;

      cc_unit u_unit (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .lnk(lnk[i])
      );
   end

   // pins: array output where a unit drives, else port values
   assign io_pin_o = (drv & lvl) | (~drv & gpio_o);
   assign io_pin_oe_n = (drv & '0) | (~drv & gpio_oe_n);

   // shared interrupt
   assign irq = (ovf_q && cmode_q[`CMODE_OVF_IE]) || |(flag_q & ie);

   ////////////////////////////////////////////////////////////////////////
   // read mux, data one cycle after the strobe
   always_comb begin
      rd_mux = `RST_BYTE;
      if (addr == `ADDR_COUNTER_MODE) rd_mux = cmode_q;
      if (addr == `ADDR_COUNTER_CTRL) rd_mux = {ovf_q, run_q, 1'b0, 5'(flag_q)};
      if (addr == `ADDR_COUNT_LO) rd_mux = cnt_q[7:0];
      if (addr == `ADDR_COUNT_HI) rd_mux = cnt_q[15:8];
      for (int k = 0; k < N_UNITS; k++) begin
         if (addr == `ADDR_MODE_BASE + 8'(k)) rd_mux = mode_q[k];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) rdata_q <= `RST_BYTE;
      else if (rd_en) rdata_q <= rd_mux;
   end

   // capture bytes read back through the links
   byte_t lnk_lo [N_UNITS];
   byte_t lnk_hi [N_UNITS];
   for (genvar j = 0; j < N_UNITS; j++) begin : g_cap
      assign lnk_lo[j] = lnk[j].cap_lo;
      assign lnk_hi[j] = lnk[j].cap_hi;
   end

   byte_t cap_rd;
   always_comb begin
      cap_rd = `RST_BYTE;
      for (int k = 0; k < N_UNITS; k++) begin
         if (addr == `ADDR_CAP_BASE + 8'(2 * k)) cap_rd = lnk_lo[k];
         if (addr == `ADDR_CAP_BASE + 8'(2 * k + 1)) cap_rd = lnk_hi[k];
      end
   end

   logic cap_sel_q;
   byte_t cap_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_sel_q <= 1'b0;
         cap_q <= `RST_BYTE;
      end else begin
         cap_sel_q <= rd_en && addr >= `ADDR_CAP_BASE && addr < `ADDR_CAP_BASE + 8'(2 * N_UNITS);
         if (rd_en) cap_q <= cap_rd;
      end
   end

   assign rdata = cap_sel_q ? cap_q : rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [2:0] gap_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) gap_q <= 3'h0;
      else if (slow_tick) gap_q <= 3'h0;
      else gap_q <= gap_q + 3'h1;
   end

   AST_SLOW_SPACING: assert property (@(posedge ref_clk) disable iff (!rst_n)
      slow_tick |-> (gap_q == 3'(`DIV_SLOW - 1)) || ($past(gap_q) == 3'h0 && !$past(rst_n)) || gap_q == 3'h5)
      else $error("slow source not every six cycles");
   AST_SLOW_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (src == SRC_DIV_SLOW && tick) |=> !tick [*5])
      else $error("slow source ticked too soon");
   AST_CNT_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (tick && !wr_lo_cnt && !wr_hi_cnt) |=> (cnt_q == $past(cnt_q) + 16'h0001))
      else $error("counter did not advance by one");
   AST_OVF_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ovf_evt && !wr_lo_cnt && !wr_hi_cnt) |=> (ovf_q && cnt_q == 16'h0000))
      else $error("overflow flag or wrap missing");
   AST_IDLE_HALT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cmode_q[`CMODE_IDLE_STOP] && cpu_idle && !wr_lo_cnt && !wr_hi_cnt) |=> $stable(cnt_q))
      else $error("counter moved in idle");
   AST_FLAG_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|ev) |=> ((flag_q & $past(ev)) == $past(ev)))
      else $error("event flag lost");
   AST_IRQ_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(ev & ie)) |=> irq [*1])
      else $error("enabled event did not raise the interrupt");
   AST_PIN_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (drv == '0) |-> (io_pin_o == gpio_o && io_pin_oe_n == gpio_oe_n))
      else $error("free pin not passed to the port");
   COV_OVERFLOW: cover property (@(posedge ref_clk) disable iff (!rst_n) ovf_evt);
   COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));

endmodule : prog_counter_array

// >>> counter_array_params.svh
// Purpose: offsets, field positions, reset values and divider counts for the counter array
// Assumes: byte-wide register port, one address per register
// Notes: definitions only
`ifndef COUNTER_ARRAY_PARAMS_SVH
`define COUNTER_ARRAY_PARAMS_SVH

// register offsets
`define ADDR_COUNTER_MODE 8'h00
`define ADDR_COUNTER_CTRL 8'h01
`define ADDR_COUNT_LO 8'h02
`define ADDR_COUNT_HI 8'h03
`define ADDR_MODE_BASE 8'h04
`define ADDR_CAP_BASE 8'h10

// counter_mode_register fields
`define CMODE_IDLE_STOP 7
`define CMODE_SRC_HI 2
`define CMODE_SRC_LO 1
`define CMODE_OVF_IE 0
`define CMODE_MASK 8'h87

// counter_control_register fields
`define CCTRL_OVF 7
`define CCTRL_RUN 6
`define CCTRL_MASK 8'hDF

// module_mode_register fields
`define MODE_CMP_EN 6
`define MODE_RISE 5
`define MODE_FALL 4
`define MODE_HIT 3
`define MODE_INV 2
`define MODE_PWM 1
`define MODE_IE 0
`define MODE_MASK 8'h7F

// reset values
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000

// source dividers (divide-by-2 taken for the fast source)
`define DIV_SLOW 6
`define DIV_FAST 2

`endif

// >>> counter_array_pkg.sv
// Purpose: shared types of the counter array
// Assumes: counter_array_params.svh supplies the field positions
// Notes: function decode used by the unit only
`include "counter_array_params.svh"

package counter_array_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [15:0] count_t;

   // counter clock source select
   typedef enum logic [1:0] {
      SRC_DIV_SLOW = 2'b00,
      SRC_DIV_FAST = 2'b01,
      SRC_TIMER0 = 2'b10,
      SRC_EXT_PIN = 2'b11
   } clk_src_t;

   // one function per module
   typedef enum logic [2:0] {
      FN_OFF = 3'b000,
      FN_CAPTURE = 3'b001,
      FN_TIMER = 3'b010,
      FN_TOGGLE = 3'b011,
      FN_PWM = 3'b100
   } func_t;

   // resolve mode bits into exactly one function
   function automatic func_t decode_func(input byte_t m);
      if (m[`MODE_CMP_EN] && m[`MODE_PWM]) return FN_PWM;
      if (m[`MODE_CMP_EN] && m[`MODE_HIT] && m[`MODE_INV]) return FN_TOGGLE;
      if (m[`MODE_CMP_EN] && m[`MODE_HIT]) return FN_TIMER;
      if (m[`MODE_RISE] || m[`MODE_FALL]) return FN_CAPTURE;
      return FN_OFF;
   endfunction : decode_func

endpackage : counter_array_pkg

// >>> cc_link_if.sv
// Purpose: link between the counter hub and one compare/capture unit
// Assumes: single clock domain
// Notes: pin_raw is the unsynchronised pin level
`timescale 1ns/10ps

interface cc_link_if;
   import counter_array_pkg::*;
   count_t cnt;
   logic adv;
   logic wr_lo;
   logic wr_hi;
   byte_t wdata;
   byte_t mode;
   logic pin_raw;
   byte_t cap_lo;
   byte_t cap_hi;
   logic event_p;
   logic drive;
   logic pin_level;

   modport hub (output cnt, adv, wr_lo, wr_hi, wdata, mode, pin_raw,
                input cap_lo, cap_hi, event_p, drive, pin_level);
   modport unit (input cnt, adv, wr_lo, wr_hi, wdata, mode, pin_raw,
                 output cap_lo, cap_hi, event_p, drive, pin_level);
endinterface : cc_link_if

// >>> cc_unit.sv
// Purpose: one compare/capture module: capture, software timer, toggle output, pwm
// Assumes: adv pulses the cycle after the shared counter advanced
// Notes: capture wins over a software write to the capture bytes
`timescale 1ns/10ps
`include "counter_array_params.svh"

module cc_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // link to the hub
   cc_link_if.unit lnk
);
   import counter_array_pkg::*;

   func_t fn;
   logic pin_s1_q, pin_s2_q, pin_prev_q;
   logic rise, fall, edge_ok, hit, pwm_q, tog_q;
   byte_t cap_lo_q, cap_hi_q;

   assign fn = decode_func(lnk.mode);
   assign rise = pin_s2_q & ~pin_prev_q;
   assign fall = ~pin_s2_q & pin_prev_q;
   // armed edges select the capture transition
   assign edge_ok = (lnk.mode[`MODE_RISE] & rise) | (lnk.mode[`MODE_FALL] & fall);
   // equality of shared counter and capture bytes
   assign hit = lnk.adv && (lnk.cnt == {cap_hi_q, cap_lo_q});

   // pin synchroniser and edge history
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= lnk.pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // capture bytes: capture, software write, pwm reload
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_lo_q <= `RST_BYTE;
         cap_hi_q <= `RST_BYTE;
      end else if (fn == FN_CAPTURE && edge_ok) begin
         cap_lo_q <= lnk.cnt[7:0];
         cap_hi_q <= lnk.cnt[15:8];
      end else begin
         if (lnk.wr_hi) cap_hi_q <= lnk.wdata;
         if (fn == FN_PWM && lnk.adv && lnk.cnt[7:0] == 8'h00) begin
            cap_lo_q <= cap_hi_q;
         end else if (lnk.wr_lo) begin
            cap_lo_q <= lnk.wdata;
         end
      end
   end

   // pwm level from the shared low byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pwm_q <= 1'b0;
      else pwm_q <= (lnk.cnt[7:0] >= cap_lo_q);
   end

   // toggle output
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) tog_q <= 1'b0;
      else if (fn == FN_TOGGLE && hit) tog_q <= ~tog_q;
   end

   assign lnk.cap_lo = cap_lo_q;
   assign lnk.cap_hi = cap_hi_q;
   // events only in capture, timer and toggle functions
   assign lnk.event_p = (fn == FN_CAPTURE && edge_ok) || ((fn == FN_TIMER || fn == FN_TOGGLE) && hit);
   assign lnk.drive = (fn == FN_TOGGLE) || (fn == FN_PWM);
   assign lnk.pin_level = (fn == FN_PWM) ? pwm_q : tog_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_CAPTURE_LOADS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_CAPTURE && edge_ok) |=> ({cap_hi_q, cap_lo_q} == $past(lnk.cnt)))
      else $error("capture did not load the counter");
   AST_TOGGLE_FLIPS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_TOGGLE && hit) |=> (tog_q != $past(tog_q)))
      else $error("toggle output did not invert on a hit");
   AST_PWM_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_PWM) |=> (pwm_q == ($past(lnk.cnt[7:0]) >= $past(cap_lo_q))))
      else $error("pwm level wrong");
   AST_PWM_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_PWM && lnk.adv && lnk.cnt[7:0] == 8'h00) |=> (cap_lo_q == $past(cap_hi_q)))
      else $error("duty byte not reloaded on wrap");
   AST_TIMER_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_TIMER && lnk.adv && lnk.cnt == {cap_hi_q, cap_lo_q}) |-> lnk.event_p)
      else $error("timer match without event");
   AST_PWM_SILENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fn == FN_PWM || fn == FN_OFF) |-> !lnk.event_p)
      else $error("event raised outside event functions");
   COV_CAPTURE: cover property (@(posedge ref_clk) disable iff (!rst_n) fn == FN_CAPTURE && edge_ok);
   COV_TOGGLE: cover property (@(posedge ref_clk) disable iff (!rst_n) fn == FN_TOGGLE && hit);
   COV_PWM_RELOAD: cover property (@(posedge ref_clk) disable iff (!rst_n)
      fn == FN_PWM && lnk.adv && lnk.cnt[7:0] == 8'h00);

endmodule : cc_unit

// >>> port_pin_model.sv
// Purpose: far-side model of the port pins: module pins and the external count input
// Assumes: pins change just after a rising clock edge
// Notes: a pin the array drives is read back at the array's own level
`timescale 1ns/10ps

module port_pin_model #(
   parameter int N_UNITS = 5
) (
   // clock
   input wire logic ref_clk,
   // array side of the pins
   input wire logic [N_UNITS-1:0] io_pin_o,
   input wire logic [N_UNITS-1:0] io_pin_oe_n,
   output logic [N_UNITS-1:0] io_pin_i,
   output logic ext_count_pin
);
   logic [N_UNITS-1:0] drv_q = '0;

   ////////////////////////////////////////////////////////////////////////
   // wire level: the array wins while its enable is low
   assign io_pin_i = (~io_pin_oe_n & io_pin_o) | (io_pin_oe_n & drv_q);
   initial ext_count_pin = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // move one module pin, held long enough for the synchroniser
   task automatic set_level(input int idx, input logic v);
      @(posedge ref_clk);
      drv_q[idx] <= v;
      repeat (3) @(posedge ref_clk);
   endtask : set_level

   // falling edges on the count input, each level held three cycles
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         ext_count_pin <= 1'b0;
         repeat (3) @(posedge ref_clk);
         ext_count_pin <= 1'b1;
         repeat (2) @(posedge ref_clk);
      end
   endtask : ext_pulses
endmodule : port_pin_model

// >>> prog_counter_array_tb.sv
// Purpose: self-checking bench for the counter array
// Assumes: timer 0 overflow pulses drive exact counts; pins come from port_pin_model
// Notes: each scenario is a task that judges its own results
`timescale 1ns/10ps
`include "counter_array_params.svh"

module prog_counter_array_tb;
   import counter_array_pkg::*;
   localparam byte_t a_mode = `ADDR_COUNTER_MODE;
   localparam byte_t a_ctrl = `ADDR_COUNTER_CTRL;
   localparam byte_t a_lo = `ADDR_COUNT_LO;
   localparam byte_t a_hi = `ADDR_COUNT_HI;
   localparam byte_t a_um = `ADDR_MODE_BASE;
   localparam byte_t a_cap = `ADDR_CAP_BASE;
   logic ref_clk;
   logic rst_n;
   byte_t addr;
   byte_t wdata;
   logic wr_en;
   logic rd_en;
   byte_t rdata;
   logic timer0_ovf;
   logic cpu_idle;
   logic ext_count_pin;
   logic [4:0] io_pin_i;
   logic [4:0] io_pin_o;
   logic [4:0] io_pin_oe_n;
   logic [4:0] gpio_o;
   logic [4:0] gpio_oe_n;
   logic irq;
   int miscompares;
   int n_tests;
   byte_t rd_val;
   logic lvl;

   ////////////////////////////////////////////////////////////////////////
   // design and pin model
   prog_counter_array dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .timer0_ovf(timer0_ovf), .cpu_idle(cpu_idle),
      .ext_count_pin(ext_count_pin), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_pin_oe_n(io_pin_oe_n),
      .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .irq(irq));
   port_pin_model pins (.ref_clk(ref_clk), .io_pin_o(io_pin_o), .io_pin_oe_n(io_pin_oe_n),
      .io_pin_i(io_pin_i), .ext_count_pin(ext_count_pin));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // comparisons and closing report
   task automatic chk8(input string what, input byte_t exp, input byte_t got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %02h seen %02h", what, exp, got);
      end
   endtask : chk8

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_range(input string what, input int lo, input int hi, input byte_t got);
      n_tests++;
      if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
         miscompares++;
         $display("FAIL %s expected %0d..%0d seen %02h", what, lo, hi, got);
      end
   endtask : chk_range

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // register port and event helpers
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd_chk(input string what, input byte_t a, input byte_t exp);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      rd_val = rdata;
      if (what != "") chk8(what, exp, rd_val);
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         timer0_ovf <= 1'b1;
         @(posedge ref_clk);
         timer0_ovf <= 1'b0;
      end
      settle(6);
   endtask : tick

   task automatic start(input byte_t m, input count_t c, input logic go);
      wr(a_ctrl, 8'h00);
      wr(a_mode, m);
      wr(a_lo, c[7:0]);
      wr(a_hi, c[15:8]);
      if (go) wr(a_ctrl, 8'h40);
   endtask : start

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset();
      settle(1);
      chk_bit("irq", 1'b0, irq);
      chk8("pin out", {3'h0, gpio_o}, {3'h0, io_pin_o});
      chk8("pin oe", {3'h0, gpio_oe_n}, {3'h0, io_pin_oe_n});
      rd_chk("ctrl", a_ctrl, 8'h00);
      wr(a_mode, 8'hFF);
      rd_chk("mode reserved", a_mode, 8'h87);
      wr(8'h30, 8'hFF);
      rd_chk("unmapped", 8'h30, 8'h00);
      $display("test reset done");
   endtask : test_reset

   task automatic test_sources();
      start(8'h04, 16'h0000, 1'b1);
      tick(3);
      rd_chk("timer0 count", a_lo, 8'h03);
      wr(a_mode, 8'h06);
      pins.ext_pulses(4);
      settle(6);
      rd_chk("ext count", a_lo, 8'h07);
      start(8'h02, 16'h0000, 1'b1);
      settle(60);
      wr(a_ctrl, 8'h00);
      rd_chk("", a_lo, 8'h00);
      chk_range("div2 count", 28, 32, rd_val);
      start(8'h00, 16'h0000, 1'b1);
      settle(120);
      wr(a_ctrl, 8'h00);
      rd_chk("", a_lo, 8'h00);
      chk_range("div6 count", 18, 22, rd_val);
      $display("test sources done");
   endtask : test_sources

   task automatic test_overflow();
      start(8'h05, 16'hFFFF, 1'b1);
      tick(1);
      rd_chk("wrap lo", a_lo, 8'h00);
      rd_chk("wrap hi", a_hi, 8'h00);
      rd_chk("ovf flag", a_ctrl, 8'hC0);
      chk_bit("ovf irq", 1'b1, irq);
      wr(a_ctrl, 8'h40);
      rd_chk("ovf clear", a_ctrl, 8'h40);
      chk_bit("irq clear", 1'b0, irq);
      wr(a_mode, 8'h04);
      wr(a_lo, 8'hFF);
      wr(a_hi, 8'hFF);
      tick(1);
      chk_bit("ovf irq masked", 1'b0, irq);
      @(posedge ref_clk);
      cpu_idle <= 1'b1;
      start(8'h84, 16'h0000, 1'b1);
      tick(3);
      rd_chk("idle stop", a_lo, 8'h00);
      wr(a_mode, 8'h04);
      tick(2);
      rd_chk("idle run", a_lo, 8'h02);
      @(posedge ref_clk);
      cpu_idle <= 1'b0;
      $display("test overflow and idle done");
   endtask : test_overflow

   task automatic test_capture();
      start(8'h00, 16'h1234, 1'b0);
      wr(a_um, 8'h21);
      pins.set_level(0, 1'b1);
      settle(4);
      rd_chk("cap0 lo", a_cap, 8'h34);
      rd_chk("cap0 hi", a_cap + 8'h01, 8'h12);
      rd_chk("cap0 flag", a_ctrl, 8'h01);
      chk_bit("cap0 irq", 1'b1, irq);
      wr(a_ctrl, 8'h00);
      rd_chk("cap0 clear", a_ctrl, 8'h00);
      chk_bit("cap0 irq clear", 1'b0, irq);
      wr(a_um + 8'h01, 8'h10);
      wr(a_cap + 8'h02, 8'h00);
      wr(a_lo, 8'h78);
      wr(a_hi, 8'h56);
      pins.set_level(1, 1'b1);
      settle(4);
      rd_chk("cap1 rise ignored", a_cap + 8'h02, 8'h00);
      pins.set_level(1, 1'b0);
      settle(4);
      rd_chk("cap1 lo", a_cap + 8'h02, 8'h78);
      rd_chk("cap1 hi", a_cap + 8'h03, 8'h56);
      rd_chk("cap1 flag", a_ctrl, 8'h02);
      chk_bit("cap1 irq masked", 1'b0, irq);
      wr(a_um, 8'h00);
      wr(a_um + 8'h01, 8'h00);
      $display("test capture done");
   endtask : test_capture

   task automatic test_compare();
      wr(a_cap + 8'h04, 8'h05);
      wr(a_cap + 8'h05, 8'h00);
      wr(a_cap + 8'h06, 8'h03);
      wr(a_cap + 8'h07, 8'h00);
      wr(a_um + 8'h02, 8'h48);
      wr(a_um + 8'h03, 8'h4C);
      start(8'h04, 16'h0000, 1'b1);
      settle(2);
      lvl = io_pin_o[3];
      chk8("oe mix", {3'h0, gpio_oe_n & 5'h17}, {3'h0, io_pin_oe_n});
      tick(3);
      chk_bit("toggle out", ~lvl, io_pin_o[3]);
      rd_chk("toggle flag", a_ctrl, 8'h48);
      tick(2);
      rd_chk("timer flag", a_ctrl, 8'h4C);
      chk_bit("timer irq masked", 1'b0, irq);
      chk_bit("toggle held", ~lvl, io_pin_o[3]);
      wr(a_um + 8'h02, 8'h00);
      wr(a_um + 8'h03, 8'h00);
      $display("test compare done");
   endtask : test_compare

   task automatic test_pwm();
      wr(a_cap + 8'h08, 8'h80);
      wr(a_cap + 8'h09, 8'h40);
      wr(a_um + 8'h04, 8'h42);
      start(8'h04, 16'h007E, 1'b1);
      tick(1);
      chk_bit("pwm below", 1'b0, io_pin_o[4]);
      tick(1);
      chk_bit("pwm equal", 1'b1, io_pin_o[4]);
      wr(a_lo, 8'hFF);
      tick(1);
      rd_chk("pwm reload", a_cap + 8'h08, 8'h40);
      chk_bit("pwm after reload", 1'b0, io_pin_o[4]);
      wr(a_lo, 8'h3F);
      tick(1);
      chk_bit("pwm new duty", 1'b1, io_pin_o[4]);
      chk_bit("pwm oe", 1'b0, io_pin_oe_n[4]);
      wr(a_um + 8'h04, 8'h02);
      settle(3);
      chk_bit("pwm without cmp", gpio_oe_n[4], io_pin_oe_n[4]);
      $display("test pwm done");
   endtask : test_pwm

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      timer0_ovf = 1'b0;
      cpu_idle = 1'b0;
      gpio_o = 5'h15;
      gpio_oe_n = 5'h1B;
      miscompares = 0;
      n_tests = 0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      test_reset();
      test_sources();
      test_overflow();
      test_capture();
      test_compare();
      test_pwm();
      give_verdict();
   end

   // hang guard
   initial begin
      repeat (50000) @(posedge ref_clk);
      miscompares++;
      $display("FAIL run length expected finish seen hang");
      give_verdict();
   end
endmodule : prog_counter_array_tb
